// ==== design/alt_reg_bank.sv ====
// six base registers and their alternates, with a whole-set swap
// assumes the core never writes and swaps in the same cycle
`timescale 1ns/1ns
module alt_reg_bank #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,  // system clock
  input  wire logic         reset,    // sync reset, high
  input  wire logic         swap,     // exchange base and alternate sets
  input  wire logic         wr_en,    // write base register
  input  wire logic [2:0]   wr_sel,   // register to write
  input  wire logic [W-1:0] wr_data,  // write data
  input  wire logic [2:0]   rd_sel,   // register to read
  output logic      [W-1:0] rd_data   // registered read data
);

  logic [W-1:0] base_r [xhi_pkg::NREGS];
  logic [W-1:0] alt_r  [xhi_pkg::NREGS];
  logic [W-1:0] base_nxt [xhi_pkg::NREGS];
  logic [W-1:0] alt_nxt  [xhi_pkg::NREGS];
  logic [W-1:0] rd_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    for (int i = 0; i < xhi_pkg::NREGS; i++)
    begin
      base_nxt[i] = base_r[i];
      alt_nxt[i]  = alt_r[i];
      if (swap)
      begin
        base_nxt[i] = alt_r[i];
        alt_nxt[i]  = base_r[i];
      end
      else if (wr_en && wr_sel == 3'(i))
        base_nxt[i] = wr_data;
    end
    rd_nxt = '0;
    for (int i = 0; i < xhi_pkg::NREGS; i++)
      if (rd_sel == 3'(i))
        rd_nxt = base_r[i];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < xhi_pkg::NREGS; i++)
      begin
        base_r[i] <= '0;
        alt_r[i]  <= '0;
      end
      rd_data <= '0;
    end
    else
    begin
      base_r  <= base_nxt;
      alt_r   <= alt_nxt;
      rd_data <= rd_nxt;
    end
  end

endmodule : alt_reg_bank

// ==== design/cpu_exchange_halt_intmode_ops.sv ====
// decoder and sequencer for register swap, halt and interrupt mode select,
// plus the maskable interrupt acknowledge sequence that the mode governs
// assumes the core presents each opcode byte it fetches as a one-cycle
// strobe, that interrupt enable logic outside raises int_accept, and that
// the core's length decoder gives the byte count of an injected opcode
`timescale 1ns/1ns
module cpu_exchange_halt_intmode_ops (
  input  wire logic          clk_sys,      // system clock, 25 MHz
  input  wire logic          reset,        // sync reset, high
  input  wire xhi_pkg::byte_s op_in,       // fetched opcode byte strobe
  input  wire logic          int_accept,   // maskable interrupt accepted
  input  wire xhi_pkg::byte_s ack_in,      // data bus in acknowledge cycle
  input  wire logic [1:0]    tail_len,     // bytes after injected opcode
  input  wire xhi_pkg::byte_s mem_in,      // data of an ordinary read
  input  wire logic [7:0]    i_page,       // interrupt page register
  input  wire logic          wr_en,        // base register write
  input  wire logic [2:0]    wr_sel,       // base register select
  input  wire logic [7:0]    wr_data,      // base register write data
  input  wire logic [2:0]    rd_sel,       // base register read select
  output logic      [7:0]    rd_data,      // base register read data
  output logic               halted,       // in halted loop
  output logic               nop_cycle,    // a no-operation cycle runs
  output logic               fetch_hold,   // core must not fetch
  output logic               ack_req,      // run acknowledge cycle
  output logic               tail_req,     // run ordinary read for tail
  output logic      [1:0]    int_mode,     // stored mode, 0..2
  output xhi_pkg::byte_s     inject,       // byte for the core to execute
  output xhi_pkg::jump_s     jump,         // restart / vector jump
  output logic               flags_we,     // flag register write
  output logic               swap_done     // swap opcode was seen in the previous cycle
);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  typedef enum logic [2:0] {
    ST_RUN,
    ST_PREFIX,
    ST_HALT,
    ST_ACK,
    ST_TAIL
  } seq_e;

  seq_e            st_r;
  seq_e            st_nxt;
  xhi_pkg::imode_e mode_r;
  xhi_pkg::imode_e mode_nxt;
  logic [1:0]      tail_r;
  logic [1:0]      tail_nxt;
  xhi_pkg::byte_s  inject_r;
  xhi_pkg::byte_s  inject_nxt;
  logic            swap_r;
  logic            swap_nxt;
  logic            swap_now;
  xhi_pkg::byte_s  ack_take;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_mode_sel(input logic [7:0] b);
    is_mode_sel = (b[7:5] == xhi_pkg::IMS_HI) &&
                  (b[2:0] == xhi_pkg::IMS_LO);
  endfunction : is_mode_sel

  // 01 is not listed; it is taken as mode 0
  function automatic xhi_pkg::imode_e mm_to_mode(input logic [1:0] mm);
    unique case (mm)
      xhi_pkg::MM_MODE1: mm_to_mode = xhi_pkg::IMODE_1;
      xhi_pkg::MM_MODE2: mm_to_mode = xhi_pkg::IMODE_2;
      default:           mm_to_mode = xhi_pkg::IMODE_0;
    endcase
  endfunction : mm_to_mode

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    st_nxt     = st_r;
    mode_nxt   = mode_r;
    tail_nxt   = tail_r;
    inject_nxt = '{valid: 1'b0, data: xhi_pkg::BYTE_RST};
    swap_nxt   = 1'b0;
    unique case (st_r)
      ST_RUN:
      begin
        // an accepted interrupt wins over an opcode in the same cycle
        if (int_accept)
          st_nxt = ST_ACK;
        else if (op_in.valid)
        begin
          if (op_in.data == xhi_pkg::OP_SWAP)
            swap_nxt = 1'b1;
          else if (op_in.data == xhi_pkg::OP_HALT)
            st_nxt = ST_HALT;
          else if (op_in.data == xhi_pkg::OP_PREFIX)
            st_nxt = ST_PREFIX;
        end
      end
      ST_PREFIX:
      begin
        if (op_in.valid)
        begin
          if (is_mode_sel(op_in.data))
            mode_nxt = mm_to_mode(
              op_in.data[xhi_pkg::IMS_FLD_LO +: 2]);
          st_nxt = ST_RUN;
        end
      end
      ST_HALT:
      begin
        // nothing but an accepted interrupt leaves; reset acts below
        if (int_accept)
          st_nxt = ST_ACK;
      end
      ST_ACK:
      begin
        if (ack_in.valid)
        begin
          if (mode_r == xhi_pkg::IMODE_0)
          begin
            inject_nxt = ack_in;
            tail_nxt   = tail_len;
            st_nxt     = (tail_len != xhi_pkg::TAIL_RST) ? ST_TAIL
                                                         : ST_RUN;
          end
          else
            st_nxt = ST_RUN;
        end
      end
      ST_TAIL:
      begin
        if (mem_in.valid)
        begin
          inject_nxt = mem_in;
          tail_nxt   = tail_r - 2'h1;
          if (tail_r == 2'h1)
            st_nxt = ST_RUN;
        end
      end
      default:
      begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r     <= ST_RUN;
      mode_r   <= xhi_pkg::IMODE_0;
      tail_r   <= xhi_pkg::TAIL_RST;
      inject_r <= '{valid: 1'b0, data: xhi_pkg::BYTE_RST};
      swap_r   <= 1'b0;
    end
    else
    begin
      st_r     <= st_nxt;
      mode_r   <= mode_nxt;
      tail_r   <= tail_nxt;
      inject_r <= inject_nxt;
      swap_r   <= swap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank; the swap acts in the cycle the opcode is seen, so the
  // next read already shows the exchanged set

  assign swap_now = (st_r == ST_RUN) && !int_accept && op_in.valid &&
                    (op_in.data == xhi_pkg::OP_SWAP);

  alt_reg_bank #(
    .W       (8)
  ) u_bank (
    .clk_sys (clk_sys),
    .reset   (reset),
    .swap    (swap_now),
    .wr_en   (wr_en),
    .wr_sel  (wr_sel),
    .wr_data (wr_data),
    .rd_sel  (rd_sel),
    .rd_data (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // service address for modes 1 and 2; mode 0 bytes go out on inject

  // one driver for the whole struct keeps strict tools content
  assign ack_take = '{valid: (st_r == ST_ACK) && ack_in.valid,
                      data:  ack_in.data};

  int_target_former u_target (
    .clk_sys (clk_sys),
    .reset   (reset),
    .mode    (mode_r),
    .ack_in  (ack_take),
    .i_page  (i_page),
    .jump    (jump)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign halted     = (st_r == ST_HALT);
  assign nop_cycle  = (st_r == ST_HALT);
  assign fetch_hold = (st_r == ST_HALT) ||
                      (st_r == ST_ACK)  ||
                      (st_r == ST_TAIL);
  assign ack_req    = (st_r == ST_ACK);
  assign tail_req   = (st_r == ST_TAIL);
  assign int_mode   = 2'(mode_r);
  assign inject     = inject_r;
  assign swap_done  = swap_r;
  // none of these operations touch the flags
  assign flags_we   = 1'b0;

endmodule : cpu_exchange_halt_intmode_ops

// ==== design/int_target_former.sv ====
// forms the service address for modes 1 and 2; mode 2 uses the acknowledge byte
// assumes ack_in.valid is a one-cycle strobe of the acknowledge data
`timescale 1ns/1ns
module int_target_former (
  input  wire logic            clk_sys,  // system clock
  input  wire logic            reset,    // sync reset, high
  input  wire xhi_pkg::imode_e mode,     // stored interrupt mode
  input  wire xhi_pkg::byte_s  ack_in,   // acknowledge data strobe
  input  wire logic [7:0]      i_page,   // interrupt page register
  output xhi_pkg::jump_s       jump      // registered jump request
);

  xhi_pkg::jump_s jump_nxt;

  always_comb
  begin
    jump_nxt.valid = 1'b0;
    jump_nxt.addr  = xhi_pkg::ADDR_RST;
    if (ack_in.valid)
    begin
      unique case (mode)
        xhi_pkg::IMODE_0:
        begin
          jump_nxt.valid = 1'b0;
        end
        xhi_pkg::IMODE_1:
        begin
          jump_nxt.valid = 1'b1;
          jump_nxt.addr  = xhi_pkg::RESTART_ADDR;
        end
        xhi_pkg::IMODE_2:
        begin
          jump_nxt.valid = 1'b1;
          jump_nxt.addr  = {i_page, ack_in.data};
        end
        default:
        begin
          jump_nxt.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      jump <= '{valid: 1'b0, addr: xhi_pkg::ADDR_RST};
    else
      jump <= jump_nxt;
  end

endmodule : int_target_former

// ==== design/xhi_pkg.sv ====
// constants and carrier types shared by the swap/halt/mode decoder
// assumes one rising-edge clock and a synchronous active-high reset
//
// Functional notes
// - swap opcode exchanges B,C,D,E,H,L with their alternates at once
// - swap, halt and mode select never write the flag register
// - halt stops fetching and runs no-operation cycles instead
// - only an accepted interrupt or a reset ends the halted loop
// - mode select stores mode; field 00 mode 0, 10 mode 1, 11 mode 2
// - mode 0: peripheral drives an opcode in acknowledge; it is executed
// - mode 0: further bytes come from ordinary memory reads
// - mode 1: bus data ignored, restart to 0038h
// - mode 2: peripheral vector byte becomes the low address half
// - mode 2: high address half comes from the interrupt page register
package xhi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OP_SWAP    = 8'hD9;
  localparam logic [7:0] OP_HALT    = 8'h76;
  localparam logic [7:0] OP_PREFIX  = 8'hED;
  // mode select second byte is 010 mm 110
  localparam logic [2:0] IMS_HI     = 3'h2;
  localparam logic [2:0] IMS_LO     = 3'h6;
  localparam int         IMS_FLD_LO = 3;

  localparam logic [1:0] MM_MODE0   = 2'h0;
  localparam logic [1:0] MM_MODE1   = 2'h2;
  localparam logic [1:0] MM_MODE2   = 2'h3;
  localparam logic [1:0] MODE_RST   = 2'h0;

  localparam logic [15:0] RESTART_ADDR = 16'h0038;
  localparam logic [1:0]  TAIL_RST     = 2'h0;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [15:0] ADDR_RST     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // register select codes for the six swappable registers
  localparam logic [2:0] SEL_B = 3'h0;
  localparam logic [2:0] SEL_C = 3'h1;
  localparam logic [2:0] SEL_D = 3'h2;
  localparam logic [2:0] SEL_E = 3'h3;
  localparam logic [2:0] SEL_H = 3'h4;
  localparam logic [2:0] SEL_L = 3'h5;
  localparam int         NREGS = 6;

  typedef enum logic [1:0] {
    IMODE_0,
    IMODE_1,
    IMODE_2
  } imode_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } jump_s;

endpackage : xhi_pkg

// ==== verification/periph_model.sv ====
// interrupting peripheral: answers acknowledge and tail reads
// assumes ack_req and tail_req level requests from the decoder
`timescale 1ns/1ns
module periph_model #(
  parameter logic [7:0] TAIL_BASE = 8'hA0
) (
  input  wire logic       clk_sys,  // clock
  input  wire logic       reset,    // sync reset
  input  wire logic       ack_req,  // acknowledge running
  input  wire logic       tail_req, // tail reads running
  input  wire logic [7:0] ack_byte, // byte for acknowledge
  input  wire logic [1:0] tail_cnt, // tail bytes to give
  input  wire logic [1:0] lag,      // answer delay
  output xhi_pkg::byte_s  ack_in,   // acknowledge bus
  output xhi_pkg::byte_s  mem_in,   // read bus
  output logic [1:0]      tail_len  // tail count
);
  logic [1:0] wait_r;
  logic [1:0] sent_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ack_in   <= '{1'b0, 8'h00};
      mem_in   <= '{1'b0, 8'h00};
      tail_len <= 2'h0;
      wait_r   <= 2'h0;
      sent_r   <= 2'h0;
    end
    else
    begin
      ack_in.valid <= 1'b0;
      mem_in.valid <= 1'b0;
      // released bus: keep changing so a stale byte is never read as valid
      ack_in.data  <= ~ack_in.data;
      mem_in.data  <= ~mem_in.data;
      if (!ack_req && !tail_req)
        wait_r <= 2'h0;
      else if (wait_r != lag)
        wait_r <= wait_r + 2'h1;
      else if (ack_req && !ack_in.valid)
      begin
        ack_in   <= '{1'b1, ack_byte};
        tail_len <= tail_cnt;
        sent_r   <= 2'h0;
        wait_r   <= 2'h0;
      end
      else if (tail_req && !mem_in.valid && sent_r != tail_cnt)
      begin
        mem_in <= '{1'b1, TAIL_BASE + {6'h00, sent_r}};
        sent_r <= sent_r + 2'h1;
        wait_r <= 2'h0;
      end
    end
  end
endmodule : periph_model

// ==== verification/testbench.sv ====
// self-checking bench for the swap, halt and interrupt mode decoder
// assumes the peripheral model on the acknowledge side
`timescale 1ns/1ns
module testbench;
  logic           clk_sys, reset, int_accept, wr_en;
  logic           halted, nop_cycle, fetch_hold, ack_req, tail_req;
  logic           flags_we, swap_done;
  xhi_pkg::byte_s op_in, ack_in, mem_in, inject;
  xhi_pkg::jump_s jump;
  logic [7:0]     i_page, wr_data, rd_data, ack_byte;
  logic [2:0]     wr_sel, rd_sel;
  logic [1:0]     tail_len, int_mode, tail_cnt, lag;
  int             n_mismatch, compares, cyc;

  cpu_exchange_halt_intmode_ops DUT (.clk_sys, .reset, .op_in, .int_accept,
    .ack_in, .tail_len, .mem_in, .i_page, .wr_en, .wr_sel, .wr_data,
    .rd_sel, .rd_data, .halted, .nop_cycle, .fetch_hold, .ack_req,
    .tail_req, .int_mode, .inject, .jump, .flags_we, .swap_done);
  periph_model PEER (.clk_sys, .reset, .ack_req, .tail_req, .ack_byte,
    .tail_cnt, .lag, .ack_in, .mem_in, .tail_len);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic op(input logic [7:0] b);
    @(negedge clk_sys) op_in <= '{1'b1, b};
    @(negedge clk_sys) op_in <= '{1'b0, 8'h00};
  endtask : op

  task automatic set_mode(input logic [1:0] mm);
    @(negedge clk_sys) op_in <= '{1'b1, xhi_pkg::OP_PREFIX};
    @(negedge clk_sys) op_in <= '{1'b1, {3'h2, mm, 3'h6}};
    @(negedge clk_sys) op_in <= '{1'b0, 8'h00};
  endtask : set_mode

  task automatic rd_chk(input logic [2:0] sel, input logic [7:0] exp);
    @(negedge clk_sys) rd_sel <= sel;
    @(negedge clk_sys) check("rd_data", rd_data, exp);
  endtask : rd_chk

  // waits for the next jump or inject pulse; bounded so a miss is reported
  task automatic take(input logic want_jump, input logic [15:0] exp);
    int k;
    for (k = 0; k < 40; k++)
    begin
      @(negedge clk_sys);
      if (want_jump ? jump.valid === 1'b1 : inject.valid === 1'b1)
        break;
    end
    // a pulse that never came must fail even if the stale data matches
    check(want_jump ? "jump.valid" : "inject.valid",
          {15'h0000, want_jump ? jump.valid : inject.valid},
          16'h0001);
    check(want_jump ? "jump" : "inject",
          want_jump ? jump.addr : {8'h00, inject.data},
          exp);
  endtask : take

  task automatic t_swap;
    int i;
    for (i = 0; i < 6; i++)
      @(negedge clk_sys) {wr_en, wr_sel, wr_data} <= {1'b1, 3'(i), 8'(16+i)};
    @(negedge clk_sys) wr_en <= 1'b0;
    op(xhi_pkg::OP_SWAP);
    check("swap_done", swap_done, 16'h0001);
    for (i = 0; i < 6; i++)
      rd_chk(3'(i), 8'h00);
    op(xhi_pkg::OP_SWAP);
    for (i = 0; i < 6; i++)
      rd_chk(3'(i), 8'(16+i));
    check("flags_we", flags_we, 16'h0000);
  endtask : t_swap

  task automatic t_modes;
    int k;
    for (k = 0; k < 4; k++)
    begin
      // field codes 00,10,11,01 give modes 0,1,2,0
      set_mode(2'(8'h78 >> (2*k)));
      @(negedge clk_sys);
      check("int_mode", int_mode, 16'(2'(8'h24 >> (2*k))));
    end
    // a prefixed byte that is not a mode select leaves the mode alone
    set_mode(2'h3);
    op(xhi_pkg::OP_PREFIX);
    op(8'h5F);
    check("int_mode", int_mode, 16'h0002);
  endtask : t_modes

  task automatic t_halt(input logic [1:0] mm, input logic [7:0] b,
                        input logic [1:0] tl, input logic [1:0] lg);
    int k;
    set_mode(mm);
    {ack_byte, tail_cnt, lag} <= {b, tl, lg};
    op(xhi_pkg::OP_HALT);
    check("halt loop", {halted, nop_cycle, fetch_hold}, 16'h0007);
    op(xhi_pkg::OP_SWAP);
    check("swap_done", swap_done, 16'h0000);
    repeat (3) @(negedge clk_sys);
    check("halted", halted, 16'h0001);
    int_accept <= 1'b1;
    @(negedge clk_sys) int_accept <= 1'b0;
    check("ack_req", ack_req, 16'h0001);
    if (mm == 2'h2)
      take(1'b1, 16'h0038);
    else if (mm == 2'h3)
      take(1'b1, {i_page, b});
    else
    begin
      take(1'b0, {8'h00, b});
      check("ack, tail", {ack_req, tail_req},
            {14'h0000, 1'b0, tl != 2'h0});
      for (k = 0; k < tl; k++)
        take(1'b0, 16'h00A0 + 16'(k));
    end
    check("halted", halted, 16'h0000);
  endtask : t_halt

  task automatic t_halt_reset;
    set_mode(2'h3);
    op(xhi_pkg::OP_HALT);
    check("halted", halted, 16'h0001);
    reset <= 1'b1;
    repeat (2) @(negedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check("halted", halted, 16'h0000);
    check("int_mode", int_mode, 16'h0000);
  endtask : t_halt_reset

  initial
  begin
    {reset, op_in, int_accept, wr_en, wr_sel, wr_data} = {1'b1, 22'h000000};
    {rd_sel, i_page, ack_byte, tail_cnt, lag} = {3'h0, 8'h5A, 12'h000};
    repeat (2) @(negedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys) check("int_mode", int_mode, 16'h0000);
    t_swap();
    t_modes();
    t_halt(2'h0, 8'hC3, 2'h2, 2'h1);
    t_halt(2'h2, 8'h77, 2'h0, 2'h0);
    t_halt(2'h3, 8'hE4, 2'h0, 2'h2);
    t_halt_reset();
    tally_and_finish();
  end
endmodule : testbench

// ==== verification/xhi_assertions.sv ====
// port checker for the swap, halt and interrupt mode decoder
// assumes a bind onto the top module and its single clock domain
`timescale 1ns/1ns
module xhi_assertions (
  input wire logic           clk_sys,    // clock
  input wire logic           reset,      // sync reset
  input wire xhi_pkg::byte_s op_in,      // opcode strobe
  input wire logic           int_accept, // interrupt taken
  input wire xhi_pkg::byte_s ack_in,     // acknowledge data
  input wire xhi_pkg::byte_s mem_in,     // tail read data
  input wire logic [7:0]     i_page,     // page register
  input wire logic           halted,     // halt state
  input wire logic           nop_cycle,  // no-op running
  input wire logic           fetch_hold, // fetch blocked
  input wire logic           ack_req,    // acknowledge wanted
  input wire logic           tail_req,   // tail wanted
  input wire logic [1:0]     int_mode,   // stored mode
  input wire xhi_pkg::byte_s inject,     // byte to execute
  input wire xhi_pkg::jump_s jump,       // jump request
  input wire logic           flags_we,   // flag write
  input wire logic           swap_done   // swap pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  a_flags_untouched: assert property (!flags_we)
    else $error("flag register written");
  a_swap_cause: assert property (
    swap_done |-> $past(op_in.valid) && $past(op_in.data) == 8'hD9)
    else $error("swap pulse without swap opcode");
  a_halt_cause: assert property (
    $rose(halted) |-> $past(op_in.valid) && $past(op_in.data) == 8'h76)
    else $error("halt entered without halt opcode");
  a_halt_idles: assert property (
    halted |-> nop_cycle && fetch_hold)
    else $error("halt loop fetches or skips no-op");
  a_halt_holds: assert property (
    halted && !int_accept |=> halted)
    else $error("halt left without interrupt");
  a_halt_wakes: assert property (
    halted && int_accept |=> ack_req && !halted)
    else $error("accepted interrupt did not start acknowledge");
  a_mode_cause: assert property (
    $changed(int_mode) |-> $past(op_in.valid))
    else $error("mode changed without opcode");
  a_reset_mode: assert property (
    disable iff (1'b0) reset |=> int_mode == 2'h0)
    else $error("mode not zero after reset");
  a_mode0_inject: assert property (
    ack_req && ack_in.valid && int_mode == 2'h0
      |=> inject.valid && inject.data == $past(ack_in.data))
    else $error("mode 0 byte not injected");
  a_tail_inject: assert property (
    tail_req && mem_in.valid
      |=> inject.valid && inject.data == $past(mem_in.data))
    else $error("tail byte not injected");
  a_mode1_restart: assert property (
    ack_req && ack_in.valid && int_mode == 2'h1
      |=> jump.valid && jump.addr == 16'h0038)
    else $error("mode 1 restart address wrong");
  a_mode2_vector: assert property (
    ack_req && ack_in.valid && int_mode == 2'h2
      |=> jump.valid && jump.addr == {$past(i_page), $past(ack_in.data)})
    else $error("mode 2 vector address wrong");
  c_swap: cover property (swap_done);
  c_wake: cover property (halted && int_accept);
  c_vector: cover property (jump.valid && int_mode == 2'h2);
  c_tail: cover property (tail_req && mem_in.valid);
endmodule : xhi_assertions

bind cpu_exchange_halt_intmode_ops xhi_assertions chk (.clk_sys, .reset,
  .op_in, .int_accept, .ack_in, .mem_in, .i_page, .halted, .nop_cycle,
  .fetch_hold, .ack_req, .tail_req, .int_mode, .inject, .jump, .flags_we,
  .swap_done);
